/* core/ipr_consts.vh */
// Constants for the interrupt priority control block
`ifndef IPR_CONSTS_VH
`define IPR_CONSTS_VH

// Register byte offsets
`define IPR_OFS_EXT34      8'h00
`define IPR_OFS_RTC        8'h04
`define IPR_OFS_CRCUART    8'h08
`define IPR_OFS_CTRL1      8'h0C
`define IPR_OFS_PEND       8'h10
`define IPR_OFS_ENABLE     8'h14
`define IPR_OFS_STATUS     8'h18

// Field positions (low bit of each 3-bit level field; bit of the nesting disable)
`define IPR_EXT4_LSB       8
`define IPR_EXT3_LSB       4
`define IPR_CAL_LSB        8
`define IPR_CHK_LSB        12
`define IPR_SER2_LSB       8
`define IPR_SER1_LSB       4
`define IPR_NEST_DIS_BIT   15

// Levels: field reset, off, top user, timed mask limit, trap base; status level field position
`define IPR_LVL_RESET      3'h4
`define IPR_LVL_OFF        3'h0
`define IPR_LVL_TOP_USER   4'h7
`define IPR_LVL_TIMED_IRQ_MASK_MAX   4'h6
`define IPR_TRAP_BASE      4'h8
`define IPR_IPL_LSB        5

// Counts and widths
`define IPR_NUM_USER       6
`define IPR_NUM_TRAP       4
`define IPR_NUM_SRC        10
`define IPR_TIMED_IRQ_MASK_W         14

// AXI responses
`define IPR_RESP_OKAY      2'h0
`define IPR_RESP_SLVERR    2'h2

`endif

/* core/ipr_level_stack.v */
// Stack of saved CPU priority levels for nested service
`timescale 1ns/1ps
module ipr_level_stack #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         ref_clk, // System clock
  input  wire         rst_n,   // Synchronous reset, active low
  input  wire         push,    // Save din on top
  input  wire         pop,     // Discard the top entry
  input  wire [3:0]   din,     // Level to save
  output wire [3:0]   dout,    // Level on top
  output wire         empty    // Nothing saved
);
  reg [3:0]  mem [0:DEPTH-1];
  reg [AW:0] cnt_q;

  assign empty = (cnt_q == {(AW+1){1'b0}});
  assign dout  = empty ? 4'h0 : mem[cnt_q[AW-1:0] - 1'b1];

  // Overflow drops the push rather than corrupting older entries
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_q <= {(AW+1){1'b0}};
    end else if (push && (cnt_q < DEPTH)) begin
      mem[cnt_q[AW-1:0]] <= din;
      cnt_q <= cnt_q + 1'b1;
    end else if (pop && !empty) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // ipr_level_stack

/* core/ipr_arbiter.v */
// Picks the highest eligible request among all sources
`timescale 1ns/1ps
module ipr_arbiter #(
  parameter N = 10
) (
  input  wire [N-1:0]   elig,     // Entry may interrupt now
  input  wire [4*N-1:0] lvl_flat, // Four-bit level of each entry
  output reg            found,    // Some entry is eligible
  output reg  [3:0]     best_idx, // Index of the winner
  output reg  [3:0]     best_lvl  // Level of the winner
);
  wire [3:0] lvl [0:N-1];
  integer i;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_lvl
      assign lvl[g] = lvl_flat[4*g +: 4];
    end
  endgenerate

  // Strictly greater wins, so on a tie the lower index keeps the slot
  always @* begin
    found    = 1'b0;
    best_idx = 4'h0;
    best_lvl = 4'h0;
    for (i = 0; i < N; i = i + 1) begin
      if (elig[i] && (!found || (lvl[i] > best_lvl))) begin
        found    = 1'b1;
        best_idx = i[3:0];
        best_lvl = lvl[i];
      end
    end
  end
endmodule // ipr_arbiter

/* core/ipr_top.v */
// Interrupt priority control with AXI4-Lite register access
//
// Behaviour
// - Three-bit level per source: 7 highest, 1 lowest, 0 disables source.
// - Unimplemented bits in priority registers ignore writes and read zero.
// - Every priority field resets to level four.
// - External source four level at bits 10:8, bits 15:11 unused.
// - External source three level at bits 6:4, bits 7 and 3:0 unused.
// - Calendar level at bits 10:8, all other bits unused.
// - Checksum error level at bits 14:12.
// - Second serial error level at bits 10:8.
// - First serial error level at bits 6:4, bits 3:0 unused.
// - Nesting-disable bit 15 of control register one stops interrupt nesting; here traps still nest above a user handler.
// - A flag still set at return makes the interrupt taken again.
// - Return restores the saved priority level.
// - A trap is re-taken after return unless its flag was cleared.
// - Status byte priority raised to seven blocks all user interrupts.
// - Traps sit at levels 8 to 11 and are never masked.
// - Timed mask blocks levels 1 to 6; level 7 still interrupts.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ipr_consts.vh"
module ipr_top #(
  parameter STACK_DEPTH = 16
) (
  input  wire        ref_clk,              // 100 MHz system clock
  input  wire        rst_n,                // Synchronous reset, active low
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,         // Write address
  input  wire        s_axi_awvalid,        // Write address valid
  output wire        s_axi_awready,        // Write address ready
  input  wire [31:0] s_axi_wdata,          // Write data
  input  wire [3:0]  s_axi_wstrb,          // Write byte strobes
  input  wire        s_axi_wvalid,         // Write data valid
  output wire        s_axi_wready,         // Write data ready
  output wire [1:0]  s_axi_bresp,          // Write response
  output wire        s_axi_bvalid,         // Write response valid
  input  wire        s_axi_bready,         // Write response ready
  input  wire [7:0]  s_axi_araddr,         // Read address
  input  wire        s_axi_arvalid,        // Read address valid
  output wire        s_axi_arready,        // Read address ready
  output wire [31:0] s_axi_rdata,          // Read data
  output wire [1:0]  s_axi_rresp,          // Read response
  output wire        s_axi_rvalid,         // Read data valid
  input  wire        s_axi_rready,         // Read data ready
  // Peripheral and trap events
  input  wire [5:0]  src_event,            // One-cycle user source events
  input  wire [3:0]  trap_event,           // One-cycle trap events
  // Processor core side
  input  wire        irq_ack,              // Core takes the offered vector
  input  wire        return_from_irq,      // Core executes a return
  input  wire        status_low_byte_wr,   // Core writes its low status byte
  input  wire [7:0]  status_low_byte,      // Value written
  input  wire        timed_irq_mask_start, // Core starts a timed mask
  input  wire [13:0] timed_irq_mask_cycles, // Length of the timed mask
  output wire        irq_req,              // Request offered to the core
  output wire [3:0]  irq_vec,              // Source index offered
  output wire [3:0]  irq_level,            // Level offered
  output wire [3:0]  cpu_level             // Current CPU priority level
);
  // Source order: 0 ext3, 1 ext4, 2 calendar, 3 serial1, 4 serial2, 5 checksum
  reg  [17:0] lvl_q;
  reg         nest_dis_q;
  reg  [3:0]  trap_flag_q;
  reg  [5:0]  pend_q;
  reg  [5:0]  enable_q;
  reg  [13:0] mask_cnt_q;
  reg  [3:0]  cpu_level_q;
  reg         irq_req_q;
  reg  [3:0]  irq_vec_q;
  reg  [3:0]  irq_level_q;

  reg         awready_q;
  reg         wready_q;
  reg         aw_have_q;
  reg         w_have_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         arready_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;

  wire        wr_go;
  wire        wr_map;
  wire [15:0] wd;
  wire        b0;
  wire        b1;
  wire        mask_active;
  wire [9:0]  elig;
  wire [39:0] lvl_all;
  wire        cand;
  wire [3:0]  cand_idx;
  wire [3:0]  cand_lvl;
  wire [3:0]  saved_lvl;
  wire        stack_empty;
  wire        take;
  wire [3:0]  new_lvl;
  reg  [31:0] rd_val;
  reg         rd_map;

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq_req       = irq_req_q;
  assign irq_vec       = irq_vec_q;
  assign irq_level     = irq_level_q;
  assign cpu_level     = cpu_level_q;

  // Write runs once address and data are both held and no response waits
  assign wr_go  = aw_have_q && w_have_q && !bvalid_q;
  assign wr_map = (aw_addr_q[7:2] <= 6'h6) && (aw_addr_q[1:0] == 2'h0);
  assign wd     = w_data_q[15:0];
  assign b0     = w_strb_q[0];
  assign b1     = w_strb_q[1];

  // Address and data channels are taken in either order
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `IPR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Priority fields; only implemented bits are stored at all
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      lvl_q <= {6{`IPR_LVL_RESET}};
    end else if (wr_go) begin
      case (aw_addr_q)
        `IPR_OFS_EXT34: begin
          if (b1) lvl_q[5:3] <= wd[`IPR_EXT4_LSB +: 3];
          if (b0) lvl_q[2:0] <= wd[`IPR_EXT3_LSB +: 3];
        end
        `IPR_OFS_RTC: begin
          if (b1) lvl_q[8:6] <= wd[`IPR_CAL_LSB +: 3];
        end
        `IPR_OFS_CRCUART: begin
          if (b1) lvl_q[17:15] <= wd[`IPR_CHK_LSB +: 3];
          if (b1) lvl_q[14:12] <= wd[`IPR_SER2_LSB +: 3];
          if (b0) lvl_q[11:9]  <= wd[`IPR_SER1_LSB +: 3];
        end
        default: begin
          lvl_q <= lvl_q;
        end
      endcase
    end
  end

  // Control one: nesting disable and trap flags; software may only clear
  // a trap flag, and a trap arriving in the same cycle wins
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      nest_dis_q  <= 1'b0;
      trap_flag_q <= 4'h0;
    end else begin
      if (wr_go && (aw_addr_q == `IPR_OFS_CTRL1)) begin
        if (b1) nest_dis_q <= wd[`IPR_NEST_DIS_BIT];
        if (b0) trap_flag_q <= (trap_flag_q & wd[3:0]) | trap_event;
        else trap_flag_q <= trap_flag_q | trap_event;
      end else begin
        trap_flag_q <= trap_flag_q | trap_event;
      end
    end
  end

  // Pending flags stay set until software clears them; events win
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      pend_q   <= 6'h00;
      enable_q <= 6'h00;
    end else begin
      if (wr_go && (aw_addr_q == `IPR_OFS_PEND) && b0) begin
        pend_q <= wd[5:0] | src_event;
      end else begin
        pend_q <= pend_q | src_event;
      end
      if (wr_go && (aw_addr_q == `IPR_OFS_ENABLE) && b0) begin
        enable_q <= wd[5:0];
      end
    end
  end

  // Timed mask counts down one per cycle from the core's request
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      mask_cnt_q <= 14'h0000;
    end else if (timed_irq_mask_start) begin
      mask_cnt_q <= timed_irq_mask_cycles;
    end else if (mask_active) begin
      mask_cnt_q <= mask_cnt_q - 1'b1;
    end
  end
  assign mask_active = (mask_cnt_q != 14'h0000);

  // Per-entry eligibility; traps ignore enables and both masks
  genvar g;
  generate
    for (g = 0; g < `IPR_NUM_SRC; g = g + 1) begin : g_src
      if (g < `IPR_NUM_USER) begin : g_user
        wire [3:0] l = {1'b0, lvl_q[3*g +: 3]};
        assign lvl_all[4*g +: 4] = l;
        assign elig[g] = pend_q[g] && enable_q[g]
                         && (lvl_q[3*g +: 3] != `IPR_LVL_OFF)
                         && (l > cpu_level_q)
                         && !(mask_active && (l <= `IPR_LVL_TIMED_IRQ_MASK_MAX));
      end else begin : g_trap
        localparam integer TRAP_LVL = `IPR_TRAP_BASE + g - `IPR_NUM_USER;
        wire [3:0] l = TRAP_LVL[3:0];
        assign lvl_all[4*g +: 4] = l;
        assign elig[g] = trap_flag_q[g-`IPR_NUM_USER] && (l > cpu_level_q);
      end
    end
  endgenerate

  ipr_arbiter #(
    .N (`IPR_NUM_SRC)
  ) u_arb (
    .elig     (elig),
    .lvl_flat (lvl_all),
    .found    (cand),
    .best_idx (cand_idx),
    .best_lvl (cand_lvl)
  );

  // An acknowledge is only honoured while a request is offered
  assign take = irq_ack && irq_req_q;
  // With nesting off, a user interrupt runs at seven so no user source
  // can preempt it; traps still can
  assign new_lvl = (nest_dis_q && !irq_level_q[3]) ? `IPR_LVL_TOP_USER : irq_level_q;

  ipr_level_stack #(
    .DEPTH (STACK_DEPTH),
    .AW    (4)
  ) u_stack (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .push    (take),
    .pop     (return_from_irq && !take),
    .din     (cpu_level_q),
    .dout    (saved_lvl),
    .empty   (stack_empty)
  );

  // CPU level: entry raises it, return restores it, status writes set it
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cpu_level_q <= 4'h0;
    end else if (take) begin
      cpu_level_q <= new_lvl;
    end else if (return_from_irq && !stack_empty) begin
      cpu_level_q <= saved_lvl;
    end else if (status_low_byte_wr && !cpu_level_q[3]) begin
      cpu_level_q <= {1'b0, status_low_byte[`IPR_IPL_LSB +: 3]};
    end
  end

  // Offer to the core; dropped in the acknowledge cycle so the stale
  // winner is not offered again before the level has moved
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_req_q   <= 1'b0;
      irq_vec_q   <= 4'h0;
      irq_level_q <= 4'h0;
    end else begin
      irq_req_q   <= cand && !take && !return_from_irq;
      irq_vec_q   <= cand_idx;
      irq_level_q <= cand_lvl;
    end
  end

  // Read mux; unimplemented bits come back zero
  always @* begin
    rd_val = 32'h0000_0000;
    rd_map = 1'b1;
    case (s_axi_araddr)
      `IPR_OFS_EXT34: begin
        rd_val[`IPR_EXT4_LSB +: 3] = lvl_q[5:3];
        rd_val[`IPR_EXT3_LSB +: 3] = lvl_q[2:0];
      end
      `IPR_OFS_RTC: begin
        rd_val[`IPR_CAL_LSB +: 3] = lvl_q[8:6];
      end
      `IPR_OFS_CRCUART: begin
        rd_val[`IPR_CHK_LSB +: 3]  = lvl_q[17:15];
        rd_val[`IPR_SER2_LSB +: 3] = lvl_q[14:12];
        rd_val[`IPR_SER1_LSB +: 3] = lvl_q[11:9];
      end
      `IPR_OFS_CTRL1: begin
        rd_val[`IPR_NEST_DIS_BIT] = nest_dis_q;
        rd_val[3:0] = trap_flag_q;
      end
      `IPR_OFS_PEND: begin
        rd_val[5:0] = pend_q;
      end
      `IPR_OFS_ENABLE: begin
        rd_val[5:0] = enable_q;
      end
      `IPR_OFS_STATUS: begin
        rd_val[3:0]   = cpu_level_q;
        rd_val[4]     = mask_active;
        rd_val[5]     = irq_req_q;
        rd_val[11:8]  = irq_vec_q;
        rd_val[29:16] = mask_cnt_q;
      end
      default: begin
        rd_map = 1'b0;
      end
    endcase
  end

  // Read channel answers one cycle after the address is taken
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `IPR_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_val;
        rresp_q   <= rd_map ? `IPR_RESP_OKAY : `IPR_RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end
endmodule // ipr_top

/* verif/ipr_checker.sv */
// Port assertions for the interrupt priority block
`timescale 1ns/1ps
module ipr_checker (
  input wire        ref_clk,               // Clock
  input wire        rst_n,                 // Reset, active low
  input wire        s_axi_awvalid,         // AW valid
  input wire        s_axi_awready,         // AW ready
  input wire        s_axi_wvalid,          // W valid
  input wire        s_axi_wready,          // W ready
  input wire        s_axi_bvalid,          // B valid
  input wire [7:0]  s_axi_araddr,          // AR address
  input wire        s_axi_arvalid,         // AR valid
  input wire        s_axi_arready,         // AR ready
  input wire [31:0] s_axi_rdata,           // Read data
  input wire        irq_ack,               // Core takes vector
  input wire        return_from_irq,       // Core returns
  input wire        timed_irq_mask_start,  // Timed mask start
  input wire [13:0] timed_irq_mask_cycles, // Timed mask length
  input wire [3:0]  trap_event,            // Trap events
  input wire        irq_req,               // Request offered
  input wire [3:0]  irq_level,             // Level offered
  input wire [3:0]  cpu_level              // CPU level
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Write answer two edges after both halves are taken
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_ext_unused: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 |=>
    (s_axi_rdata & 32'hffff_f88f) == 32'h0000_0000) else $error("external level register unused bits set");
  a_cal_unused: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04 |=>
    (s_axi_rdata & 32'hffff_f8ff) == 32'h0000_0000) else $error("calendar register unused bits set");
  // Level changes are skipped so the registered request may catch up
  a_offer_above: assert property (irq_req && $stable(cpu_level) |-> irq_level > cpu_level)
    else $error("request not above cpu level");
  a_ack_drop: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request held after ack");
  a_ack_level: assert property (irq_req && irq_ack |=> cpu_level == $past(irq_level) ||
    ($past(irq_level) < 4'h8 && cpu_level == 4'h7)) else $error("cpu level wrong after ack");
  a_return_restore: assert property (irq_req && irq_ack ##1 return_from_irq |=>
    cpu_level == $past(cpu_level, 2)) else $error("return did not restore level");
  a_timed_mask: assert property (timed_irq_mask_start && timed_irq_mask_cycles > 14'h0004 |->
    ##2 (!irq_req || irq_level > 4'h6) [*3]) else $error("timed mask let a low level through");
  // A return in the middle cycle drops the offer for one cycle by design
  a_trap_offer: assert property ((trap_event != 4'h0 && cpu_level < 4'h8 && !irq_ack) ##1
    (!irq_ack && !return_from_irq) |=> irq_req && irq_level >= 4'h8) else $error("trap not offered");

  // Main scenarios reached
  c_ack: cover property (irq_req && irq_ack);
  c_trap: cover property (irq_req && irq_level >= 4'h8);
  c_mask: cover property (timed_irq_mask_start);
endmodule // ipr_checker

/* verif/ipr_core_model.sv */
// Processor core model that takes offered vectors and returns from them
`timescale 1ns/1ps
module ipr_core_model (
  input  wire ref_clk,                    // Clock
  input  wire rst_n,                      // Reset, active low
  input  wire irq_req,                    // Request offered
  input  wire core_en,                    // Core accepts vectors
  input  wire core_slow,                  // Long handlers
  output reg  irq_ack = 1'h0,             // Vector taken
  output reg  return_from_irq = 1'h0      // Handler ends
);
  reg [3:0] left_q;
  reg       busy_q;
  // One handler at a time; prompt mode returns on the very next cycle
  always @(posedge ref_clk) begin
    irq_ack <= 1'h0;
    return_from_irq <= 1'h0;
    if (!rst_n) begin
      busy_q <= 1'h0;
      left_q <= 4'h0;
    end else if (busy_q) begin
      left_q <= left_q - 4'h1;
      if (left_q == 4'h0) begin
        return_from_irq <= 1'h1;
        busy_q <= 1'h0;
      end
    end else if (core_en && irq_req) begin
      irq_ack <= 1'h1;
      busy_q <= 1'h1;
      left_q <= core_slow ? 4'h9 : 4'h0;
    end
  end
endmodule // ipr_core_model

/* verif/interrupt_priority_control_bench.sv */
// Bench for the interrupt priority block with a core model
`timescale 1ns/1ps
`include "ipr_consts.vh"
module interrupt_priority_control_bench;
  logic        ref_clk = 1'h0, rst_n = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, status_low_byte = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf, trap_event = 4'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1, status_low_byte_wr = 1'h0;
  logic        timed_irq_mask_start = 1'h0, core_en = 1'h0, core_slow = 1'h0;
  logic [5:0]  src_event = 6'h00;
  logic [13:0] timed_irq_mask_cycles = 14'h0000;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         irq_ack, return_from_irq, irq_req;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [3:0]   irq_vec, irq_level, cpu_level;
  integer      seed = 66102, fail_count = 0, total_checks = 0, cyc = 0, i, k;
  logic [31:0] rd;
  logic [1:0]  rr;
  logic [7:0]  ofs [3] = '{`IPR_OFS_EXT34, `IPR_OFS_RTC, `IPR_OFS_CRCUART};

  ipr_top i_ipr_top (.*);
  ipr_core_model i_ipr_core_model (.*);

  always #5 ref_clk = ~ref_clk;

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fail_count = fail_count + 1;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Write, releasing each channel once it is taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    chk(s_axi_bresp, r);
  endtask

  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask

  task automatic stw(input logic [7:0] v);
    status_low_byte <= v;
    status_low_byte_wr <= 1'h1;
    @(posedge ref_clk);
    status_low_byte_wr <= 1'h0;
  endtask

  task automatic ev(input logic [5:0] s, input logic [3:0] t);
    src_event <= s;
    trap_event <= t;
    @(posedge ref_clk);
    src_event <= 6'h00;
    trap_event <= 4'h0;
  endtask

  task automatic mask(input int n);
    timed_irq_mask_cycles <= n[13:0];
    timed_irq_mask_start <= 1'h1;
    @(posedge ref_clk);
    timed_irq_mask_start <= 1'h0;
  endtask

  function automatic logic [31:0] at(input logic [2:0] l, input int s);
    return {29'h0, l} << s;
  endfunction

  // Register image with every field of register r at level l
  function automatic logic [31:0] fill(input int r, input logic [2:0] l);
    case (r)
      0: return at(l, `IPR_EXT4_LSB) | at(l, `IPR_EXT3_LSB);
      1: return at(l, `IPR_CAL_LSB);
      default: return at(l, `IPR_CHK_LSB) | at(l, `IPR_SER2_LSB) | at(l, `IPR_SER1_LSB);
    endcase
  endfunction

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    for (i = 0; i < 3; i++) begin
      axr(ofs[i]);
      chk(rd, fill(i, `IPR_LVL_RESET));
    end
    $display("Test reset values done");
    // Random data: only the level fields keep what is written
    for (i = 0; i < 9; i++) begin
      k = $random(seed);
      axw(ofs[i % 3], k, `IPR_RESP_OKAY);
      axr(ofs[i % 3]);
      chk(rd, k & fill(i % 3, 3'h7));
    end
    axw(8'h40, 32'hffff_ffff, `IPR_RESP_SLVERR);
    axr(8'h40);
    chk({rr, rd}, {`IPR_RESP_SLVERR, 32'h0000_0000});
    $display("Test field access done");
    // Flags cleared before enabling, then arbitration with a tie at level five
    axw(`IPR_OFS_PEND, 32'h0000_0000, `IPR_RESP_OKAY);
    axw(`IPR_OFS_ENABLE, 32'h0000_003f, `IPR_RESP_OKAY);
    axw(`IPR_OFS_EXT34, at(3'h5, `IPR_EXT4_LSB) | at(3'h2, `IPR_EXT3_LSB), `IPR_RESP_OKAY);
    axw(`IPR_OFS_RTC, 32'h0000_0000, `IPR_RESP_OKAY);
    axw(`IPR_OFS_CRCUART, at(3'h3, `IPR_CHK_LSB) | at(3'h1, `IPR_SER2_LSB) | at(3'h5, `IPR_SER1_LSB),
        `IPR_RESP_OKAY);
    ev(6'h3f, 4'h0);
    tick(2);
    chk({irq_req, irq_vec, irq_level}, {1'h1, 4'h1, 4'h5});
    stw(8'ha0);
    tick(2);
    chk(irq_req, 1'h0);
    axr(`IPR_OFS_STATUS);
    chk(rd[5:0], 6'h05);
    stw(8'he0);
    axw(`IPR_OFS_EXT34, at(3'h7, `IPR_EXT4_LSB), `IPR_RESP_OKAY);
    tick(2);
    chk(irq_req, 1'h0);
    stw(8'h00);
    tick(2);
    chk({irq_req, irq_vec, irq_level}, {1'h1, 4'h1, 4'h7});
    axw(`IPR_OFS_PEND, 32'h0000_0004, `IPR_RESP_OKAY);
    tick(2);
    chk(irq_req, 1'h0);
    $display("Test arbitration done");
    // Timed mask holds back level six but not level seven
    axw(`IPR_OFS_EXT34, at(3'h6, `IPR_EXT4_LSB), `IPR_RESP_OKAY);
    axw(`IPR_OFS_PEND, 32'h0000_0002, `IPR_RESP_OKAY);
    k = 20 + {$random(seed)} % 30;
    mask(k);
    tick(3);
    chk(irq_req, 1'h0);
    tick(k + 5);
    chk({irq_req, irq_level}, {1'h1, 4'h6});
    axw(`IPR_OFS_EXT34, at(3'h7, `IPR_EXT4_LSB), `IPR_RESP_OKAY);
    mask(k);
    tick(3);
    chk({irq_req, irq_level}, {1'h1, 4'h7});
    tick(k + 5);
    $display("Test timed mask done");
    // Flag left set, so the core keeps coming back
    axw(`IPR_OFS_EXT34, at(3'h3, `IPR_EXT4_LSB), `IPR_RESP_OKAY);
    core_en <= 1'h1;
    k = 0;
    repeat (30) begin
      @(posedge ref_clk);
      k = k + irq_ack;
    end
    chk(k > 2, 1'h1);
    core_en <= 1'h0;
    tick(4);
    axw(`IPR_OFS_CTRL1, 32'h0000_800f, `IPR_RESP_OKAY);
    axr(`IPR_OFS_CTRL1);
    chk(rd, 32'h0000_8000);
    core_slow <= 1'h1;
    core_en <= 1'h1;
    do @(posedge ref_clk); while (irq_ack !== 1'h1);
    @(posedge ref_clk);
    chk(cpu_level, `IPR_LVL_TOP_USER);
    ev(6'h00, 4'h2);
    tick(2);
    chk({irq_req, irq_vec, irq_level}, {1'h1, 4'h7, 4'h9});
    axw(`IPR_OFS_PEND, 32'h0000_0000, `IPR_RESP_OKAY);
    k = 0;
    repeat (60) begin
      @(posedge ref_clk);
      k = k + irq_ack;
    end
    chk(k > 2, 1'h1);
    axw(`IPR_OFS_CTRL1, 32'h0000_800d, `IPR_RESP_OKAY);
    tick(40);
    chk({irq_req, cpu_level}, {1'h0, 4'h0});
    $display("Test service and traps done");
    wrap_up();
  end
endmodule // interrupt_priority_control_bench

bind ipr_top ipr_checker i_ipr_checker (.*);
